// [logic/fail_capture_mem.sv]
`timescale 1ns/1ps
// Holds the expected and received words of the first mismatch.
module fail_capture_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [WIDTH*DEPTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= wr_data[i*WIDTH +: WIDTH];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (ce) begin
			rd_data <= mem_q[rd_idx];
		end
	end

endmodule : fail_capture_mem

// [logic/fs_cmd_defs.svh]
`ifndef FS_CMD_DEFS_SVH
`define FS_CMD_DEFS_SVH

// Register byte offsets
`define REG_CMD 8'h00
`define REG_STATUS 8'h04
`define REG_ERR_TYPE 8'h08
`define REG_DATE_TIME 8'h0C
`define REG_FILE_SIZE 8'h10
`define REG_FILE_NAME 8'h14
`define REG_FILE_COUNT 8'h18
`define REG_PATTERN 8'h1C
`define REG_STORED 8'h20
`define REG_TOTAL_CAP 8'h24
`define REG_PER_DIR 8'h28
`define REG_CFG_SIZE 8'h2C
`define REG_DRV_CAP_LO 8'h30
`define REG_DRV_CAP_HI 8'h34
`define REG_CUR_LO 8'h38
`define REG_CUR_HI 8'h3C
`define REG_FAIL_BASE 8'h40
`define REG_FAIL_LAST 8'h5C
`define REG_IRQ_STS 8'h60
`define REG_IRQ_MASK 8'h64
`define REG_FAIL_ADR_LO 8'h68
`define REG_FAIL_ADR_HI 8'h6C
`define REG_FAIL_NAME 8'h70

// Command register fields and codes
`define CMD_CODE_MSB 2
`define CMD_CANCEL_BIT 3
`define CMD_FORMAT 3'h0
`define CMD_SHUTDOWN 3'h1
`define CMD_WRITE 3'h2
`define CMD_READ 3'h3
`define CMD_SECURE_FMT 3'h4

// Status bits
`define STS_BUSY 0
`define STS_ERROR 1
`define STS_VERIFY 2

// Drive capacity high register fields
`define CAP_SECURE_BIT 30
`define CAP_LBA_MODE_BIT 31

// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_ERROR 1
`define IRQ_VERIFY 2
`define IRQ_INIT 3
`define IRQ_WIDTH 4

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_MASK 4'h0

`endif

// [logic/fs_cmd_pkg.sv]
package fs_cmd_pkg;

	typedef enum logic [1:0] {
		ST_INIT,
		ST_IDLE,
		ST_BUSY,
		ST_OFF
	} ctl_state_t;

	typedef struct packed {
		logic [2:0] code;
		logic [31:0] date_time;
		logic [31:0] file_size;
		logic [26:0] file_name;
		logic [31:0] file_count;
		logic [31:0] pattern;
		logic append;
	} cmd_req_t;

	typedef struct packed {
		logic init_done;
		logic done;
		logic error;
		logic [31:0] err_type;
		logic mismatch;
	} eng_event_t;

	typedef struct packed {
		logic [127:0] received;
		logic [127:0] expected;
		logic [38:0] byte_addr;
		logic [26:0] file_name;
	} fail_info_t;

	typedef struct packed {
		logic [31:0] total_cap;
		logic [31:0] per_dir;
		logic [31:0] file_size;
		logic [31:0] stored;
		logic [47:0] lba_size;
		logic secure_ok;
		logic lba_mode;
	} capacity_t;

endpackage : fs_cmd_pkg

// [logic/fs_cmd_port.sv]
`timescale 1ns/1ps
`include "fs_cmd_defs.svh"
module fs_cmd_port
	import fs_cmd_pkg::*;
#(
	parameter int AW = 8
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [AW-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic IRQ,
	input wire eng_event_t ENG_EVENT,
	input wire fail_info_t ENG_FAIL,
	input wire logic [56:0] ENG_CUR_SIZE,
	input wire capacity_t ENG_CAPACITY,
	output cmd_req_t CMD_REQ,
	output logic CMD_START,
	output logic CMD_CANCEL,
	output logic DRIVE_ACTIVE
);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic code_valid(input logic [2:0] c);
		return c == `CMD_FORMAT || c == `CMD_SECURE_FMT ||
			c == `CMD_SHUTDOWN || c == `CMD_WRITE || c == `CMD_READ;
	endfunction : code_valid

	function automatic logic is_xfer(input logic [2:0] c);
		return c == `CMD_WRITE || c == `CMD_READ;
	endfunction : is_xfer

	function automatic logic is_format(input logic [2:0] c);
		return c == `CMD_FORMAT || c == `CMD_SECURE_FMT;
	endfunction : is_format

	ctl_state_t state_q;
	logic wait_q;
	logic wr_now;
	logic cmd_wr;
	logic cmd_go;
	logic done_evt;
	logic err_set;
	logic ver_set;
	logic init_evt;
	logic [31:0] date_time_q;
	logic [31:0] file_size_q;
	logic [26:0] file_name_q;
	logic [31:0] file_count_q;
	logic [31:0] pattern_q;
	logic err_q;
	logic verify_q;
	logic [31:0] err_type_q;
	logic [56:0] cur_size_q;
	capacity_t cap_q;
	logic [31:0] stored_q;
	logic [38:0] fail_addr_q;
	logic [26:0] fail_name_q;
	logic [`IRQ_WIDTH-1:0] irq_sts_q;
	logic [`IRQ_WIDTH-1:0] irq_mask_q;
	logic [`IRQ_WIDTH-1:0] irq_ev;
	logic [31:0] mem_rd;
	logic fail_win;
	logic [31:0] rd_word;
	logic [31:0] merged;
	logic busy;

	// Two-edge answer: the capture memory needs one edge to present data
	assign wr_now = wait_q && WB_CYC_I && WB_STB_I && WB_WE_I;
	assign merged = merge(32'h0000_0000, WB_DAT_I, WB_SEL_I);
	assign cmd_wr = wr_now && WB_ADR_I == `REG_CMD && WB_SEL_I[0];
	assign cmd_go = cmd_wr && state_q == ST_IDLE &&
		code_valid(WB_DAT_I[`CMD_CODE_MSB:0]);
	assign done_evt = state_q == ST_BUSY && ENG_EVENT.done;
	assign init_evt = state_q == ST_INIT && ENG_EVENT.init_done;
	assign err_set = state_q == ST_BUSY && ENG_EVENT.error;
	assign ver_set = state_q == ST_BUSY && CMD_REQ.code == `CMD_READ &&
		ENG_EVENT.mismatch;
	assign fail_win = WB_ADR_I >= `REG_FAIL_BASE &&
		WB_ADR_I <= `REG_FAIL_LAST;
	assign busy = state_q == ST_INIT || state_q == ST_BUSY;
	assign irq_ev = {init_evt, ver_set, err_set, done_evt};

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			wait_q <= 1'b0;
			WB_ACK_O <= 1'b0;
		end else if (CLK_EN) begin
			wait_q <= WB_CYC_I && WB_STB_I && !WB_ACK_O && !wait_q;
			WB_ACK_O <= wait_q && WB_CYC_I && WB_STB_I;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state_q <= ST_INIT;
		end else if (CLK_EN) begin
			case (state_q)
				ST_INIT: begin
					if (ENG_EVENT.init_done) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (cmd_go) begin
						state_q <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					// Mismatch has no path here: only done ends it
					if (ENG_EVENT.done) begin
						state_q <= CMD_REQ.code == `CMD_SHUTDOWN ?
							ST_OFF : ST_IDLE;
					end
				end
				ST_OFF: begin
					state_q <= ST_OFF;
				end
				default: begin
					state_q <= ST_INIT;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			date_time_q <= `RST_WORD;
			file_size_q <= `RST_WORD;
			file_name_q <= 27'h000_0000;
			file_count_q <= `RST_WORD;
			pattern_q <= `RST_WORD;
			irq_mask_q <= `RST_MASK;
		end else if (CLK_EN && wr_now) begin
			case (WB_ADR_I)
				`REG_DATE_TIME: date_time_q <= merge(date_time_q, WB_DAT_I,
					WB_SEL_I);
				`REG_FILE_SIZE: file_size_q <= merge(file_size_q, WB_DAT_I,
					WB_SEL_I);
				`REG_FILE_NAME: file_name_q <= 27'(merge({5'h00, file_name_q},
					WB_DAT_I, WB_SEL_I));
				`REG_FILE_COUNT: file_count_q <= merge(file_count_q, WB_DAT_I,
					WB_SEL_I);
				`REG_PATTERN: pattern_q <= merge(pattern_q, WB_DAT_I, WB_SEL_I);
				`REG_IRQ_MASK: irq_mask_q <= 4'(merge({28'h000_0000,
					irq_mask_q}, WB_DAT_I, WB_SEL_I));
				default: begin
				end
			endcase
		end
	end

	// Launch latches the parameters so later register writes cannot
	// disturb a command in flight
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			CMD_REQ <= '0;
			CMD_START <= 1'b0;
			CMD_CANCEL <= 1'b0;
		end else if (CLK_EN) begin
			CMD_START <= cmd_go;
			CMD_CANCEL <= cmd_wr && WB_DAT_I[`CMD_CANCEL_BIT] &&
				state_q == ST_BUSY && is_xfer(CMD_REQ.code);
			if (cmd_go) begin
				CMD_REQ.code <= WB_DAT_I[`CMD_CODE_MSB:0];
				CMD_REQ.date_time <= date_time_q;
				CMD_REQ.file_size <= file_size_q;
				CMD_REQ.file_name <= file_name_q;
				CMD_REQ.file_count <= file_count_q;
				CMD_REQ.pattern <= pattern_q;
				CMD_REQ.append <= {5'h00, file_name_q} >= stored_q;
			end
		end
	end

	// Sets are placed after the clear so a same-cycle event survives
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			err_q <= 1'b0;
			verify_q <= 1'b0;
			err_type_q <= `RST_WORD;
		end else if (CLK_EN) begin
			if (cmd_go) begin
				err_q <= 1'b0;
				verify_q <= 1'b0;
			end
			if (err_set) begin
				err_q <= 1'b1;
				err_type_q <= ENG_EVENT.err_type;
			end
			if (ver_set) begin
				verify_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			fail_addr_q <= 39'h00_0000_0000;
			fail_name_q <= 27'h000_0000;
		end else if (CLK_EN && ver_set && !verify_q) begin
			fail_addr_q <= ENG_FAIL.byte_addr;
			fail_name_q <= ENG_FAIL.file_name;
		end
	end

	fail_capture_mem #(
		.WIDTH(32),
		.DEPTH(8),
		.AW(3)
	) u_fail_mem (
		.clk(SYS_CLK),
		.ce(CLK_EN),
		.wr_en(ver_set && !verify_q),
		.wr_data({ENG_FAIL.received, ENG_FAIL.expected}),
		.rd_idx(WB_ADR_I[4:2]),
		.rd_data(mem_rd)
	);

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			cur_size_q <= 57'h000_0000_0000_0000;
		end else if (CLK_EN) begin
			if (cmd_go) begin
				cur_size_q <= 57'h000_0000_0000_0000;
			end else if (state_q == ST_BUSY && is_xfer(CMD_REQ.code)) begin
				cur_size_q <= ENG_CUR_SIZE;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			cap_q <= '0;
			stored_q <= `RST_WORD;
		end else if (CLK_EN) begin
			if (init_evt || (done_evt && is_format(CMD_REQ.code))) begin
				cap_q <= ENG_CAPACITY;
			end
			if (init_evt || done_evt) begin
				stored_q <= ENG_CAPACITY.stored;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			irq_sts_q <= `RST_MASK;
			IRQ <= 1'b0;
		end else if (CLK_EN) begin
			if (wr_now && WB_ADR_I == `REG_IRQ_STS) begin
				irq_sts_q <= (irq_sts_q & ~merged[`IRQ_WIDTH-1:0]) | irq_ev;
			end else begin
				irq_sts_q <= irq_sts_q | irq_ev;
			end
			IRQ <= |(irq_sts_q & irq_mask_q);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			DRIVE_ACTIVE <= 1'b0;
		end else if (CLK_EN) begin
			DRIVE_ACTIVE <= state_q == ST_IDLE || state_q == ST_BUSY;
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		case (WB_ADR_I)
			`REG_CMD: rd_word = {29'h0000_0000, CMD_REQ.code};
			`REG_STATUS: rd_word = {29'h0000_0000, verify_q, err_q, busy};
			`REG_ERR_TYPE: rd_word = err_type_q;
			`REG_DATE_TIME: rd_word = date_time_q;
			`REG_FILE_SIZE: rd_word = file_size_q;
			`REG_FILE_NAME: rd_word = {5'h00, file_name_q};
			`REG_FILE_COUNT: rd_word = file_count_q;
			`REG_PATTERN: rd_word = pattern_q;
			`REG_STORED: rd_word = stored_q;
			`REG_TOTAL_CAP: rd_word = cap_q.total_cap;
			`REG_PER_DIR: rd_word = cap_q.per_dir;
			`REG_CFG_SIZE: rd_word = cap_q.file_size;
			`REG_DRV_CAP_LO: rd_word = cap_q.lba_size[31:0];
			`REG_DRV_CAP_HI: rd_word = {cap_q.lba_mode, cap_q.secure_ok,
				14'h0000, cap_q.lba_size[47:32]};
			`REG_CUR_LO: rd_word = cur_size_q[31:0];
			`REG_CUR_HI: rd_word = {7'h00, cur_size_q[56:32]};
			`REG_IRQ_STS: rd_word = {28'h000_0000, irq_sts_q};
			`REG_IRQ_MASK: rd_word = {28'h000_0000, irq_mask_q};
			`REG_FAIL_ADR_LO: rd_word = fail_addr_q[31:0];
			`REG_FAIL_ADR_HI: rd_word = {25'h000_0000, fail_addr_q[38:32]};
			`REG_FAIL_NAME: rd_word = {5'h00, fail_name_q};
			default: rd_word = fail_win ? mem_rd : 32'h0000_0000;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			WB_DAT_O <= `RST_WORD;
		end else if (CLK_EN && wait_q && WB_CYC_I && WB_STB_I) begin
			WB_DAT_O <= rd_word;
		end
	end

endmodule : fs_cmd_port

// [testbench/fs_cmd_port_chk.sv]
`timescale 1ns/1ps
`include "fs_cmd_defs.svh"
module fs_cmd_port_chk
	import fs_cmd_pkg::*;
#(
	parameter int AW = 8
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [AW-1:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire eng_event_t ENG_EVENT,
	input wire cmd_req_t CMD_REQ,
	input wire logic CMD_START,
	input wire logic CMD_CANCEL,
	input wire logic DRIVE_ACTIVE
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST || !CLK_EN);
	// Launch outputs and ack both appear after the write edge
	wire cmd_wr = WB_ACK_O && WB_WE_I && WB_ADR_I == `REG_CMD;
	wire shut_done = ENG_EVENT.done && CMD_REQ.code == `CMD_SHUTDOWN;

	a_ack_latency: assert property (
		$rose(WB_CYC_I && WB_STB_I) |-> !WB_ACK_O ##1 !WB_ACK_O ##1 WB_ACK_O)
		else $error("ack not on the second edge of a request");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_rdata_held: assert property (!WB_ACK_O |-> $stable(WB_DAT_O))
		else $error("read data moved without an answer");
	a_start_cause: assert property (
		CMD_START |-> cmd_wr && DRIVE_ACTIVE)
		else $error("start without a command write");
	a_start_code: assert property (
		CMD_START |-> CMD_REQ.code == $past(WB_DAT_I[2:0]))
		else $error("launched code differs from written code");
	a_cancel_cause: assert property (
		CMD_CANCEL |-> cmd_wr && WB_DAT_I[`CMD_CANCEL_BIT])
		else $error("cancel without a cancel write");
	a_off_after_done: assert property (
		DRIVE_ACTIVE && shut_done |-> ##[1:3] !DRIVE_ACTIVE)
		else $error("drive still active after shutdown");
	a_off_no_start: assert property (!DRIVE_ACTIVE |-> !CMD_START)
		else $error("command launched while drive inactive");

	cover property (CMD_CANCEL);
	cover property ($fell(DRIVE_ACTIVE));
	cover property (CMD_START && CMD_REQ.code == `CMD_READ);
endmodule : fs_cmd_port_chk

bind fs_cmd_port fs_cmd_port_chk #(.AW(AW)) chk_i (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .ENG_EVENT(ENG_EVENT), .CMD_REQ(CMD_REQ),
	.CMD_START(CMD_START), .CMD_CANCEL(CMD_CANCEL),
	.DRIVE_ACTIVE(DRIVE_ACTIVE));

// [testbench/fs_cmd_port_tb.sv]
`timescale 1ns/1ps
`include "fs_cmd_defs.svh"
module fs_cmd_port_tb
	import fs_cmd_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] dat_o, rdat;
	logic ack, irq, start, cancel, active;
	logic [56:0] cur = '0;
	logic [2:0] codes [2] = '{`CMD_FORMAT, `CMD_SECURE_FMT};
	eng_event_t ev = '0;
	fail_info_t fail = '0;
	capacity_t cap = '0;
	cmd_req_t req;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int starts = 0;
	int cancels = 0;
	int n;

	always #2.5 clk = ~clk;

	fs_cmd_port #(.AW(8)) uut (
		.SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(ce),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.IRQ(irq), .ENG_EVENT(ev), .ENG_FAIL(fail), .ENG_CUR_SIZE(cur),
		.ENG_CAPACITY(cap), .CMD_REQ(req), .CMD_START(start),
		.CMD_CANCEL(cancel), .DRIVE_ACTIVE(active));

	task summarize;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// Limit is far above the roughly 200 cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (start === 1'b1) starts++;
		if (cancel === 1'b1) cancels++;
		if (cycles == 5000) begin
			bad_count++;
			summarize();
		end
	end

	task chk(input logic [63:0] s, input logic [63:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : bus

	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(rdat, e);
	endtask : rd

	// Engine event pulses last exactly one cycle
	task fire(input logic d, input logic e, input logic m);
		ev.done <= d;
		ev.error <= e;
		ev.mismatch <= m;
		@(posedge clk);
		ev.done <= 1'b0;
		ev.error <= 1'b0;
		ev.mismatch <= 1'b0;
		@(posedge clk);
	endtask : fire

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`REG_STATUS, 1);
		cap.stored <= 32'h0000_0005;
		cap.lba_size <= 48'h1234_5678_9ABC;
		cap.secure_ok <= 1'b1;
		ev.init_done <= 1'b1;
		repeat (2) @(posedge clk);
		rd(`REG_STATUS, 0);
		rd(`REG_DRV_CAP_HI, 32'h4000_1234);
		bus(1'b1, `REG_STORED, 32'hFFFF_FFFF);
		rd(`REG_STORED, 5);
		rd(8'h7C, 0);
		chk(irq, 0);
		bus(1'b1, `REG_IRQ_MASK, 32'h0000_0008);
		chk(irq, 1);
		bus(1'b1, `REG_IRQ_STS, 32'h0000_0008);
		chk(irq, 0);
		bus(1'b1, `REG_DATE_TIME, 32'h5A5A_0101);
		bus(1'b1, `REG_FILE_NAME, 32'h0000_0007);
		bus(1'b1, `REG_FILE_COUNT, 32'h0000_0003);
		bus(1'b1, `REG_PATTERN, 32'h0000_0002);
		bus(1'b1, `REG_CMD, {29'h0, `CMD_WRITE});
		rd(`REG_STATUS, 1);
		chk(req.date_time, 32'h5A5A_0101);
		chk(req.append, 1);
		chk(req.file_name, 7);
		chk(req.file_count, 3);
		chk(req.pattern, 2);
		cur <= 57'h1_ABCD_EF01_2345;
		repeat (2) @(posedge clk);
		rd(`REG_CUR_LO, 32'hEF01_2345);
		rd(`REG_CUR_HI, 32'h0001_ABCD);
		ev.err_type <= 32'h0000_0007;
		fire(1'b0, 1'b1, 1'b0);
		rd(`REG_STATUS, 3);
		rd(`REG_ERR_TYPE, 7);
		fire(1'b1, 1'b0, 1'b0);
		rd(`REG_STATUS, 2);
		rd(`REG_IRQ_STS, 3);
		bus(1'b1, `REG_FILE_NAME, 32'h0000_0002);
		bus(1'b1, `REG_CMD, {29'h0, `CMD_READ});
		chk(req.append, 0);
		fail.expected <= {4{32'h1111_2222}};
		fail.received <= {4{32'h3333_4444}};
		fail.byte_addr <= 39'h45_0000_0010;
		fail.file_name <= 27'h000_0003;
		fire(1'b0, 1'b0, 1'b1);
		fail <= '0;
		fire(1'b0, 1'b0, 1'b1);
		rd(`REG_STATUS, 5);
		rd(`REG_FAIL_BASE, 32'h1111_2222);
		rd(8'h50, 32'h3333_4444);
		rd(`REG_FAIL_ADR_HI, 32'h0000_0045);
		rd(`REG_FAIL_ADR_LO, 32'h0000_0010);
		rd(`REG_FAIL_NAME, 3);
		bus(1'b1, `REG_CMD, {28'h0, 1'b1, `CMD_READ});
		chk(cancels, 1);
		// A done pulse while the enable is low must be lost entirely
		ce <= 1'b0;
		fire(1'b1, 1'b0, 1'b0);
		ce <= 1'b1;
		rd(`REG_STATUS, 5);
		fire(1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, `REG_FILE_SIZE, 32'h0000_0040 + i);
			bus(1'b1, `REG_CMD, {29'h0, codes[i]});
			chk(req.code, codes[i]);
			chk(req.file_size, 32'h0000_0040 + i);
			chk(req.date_time, 32'h5A5A_0101);
			cap.total_cap <= 32'h0000_0200 + i;
			cap.per_dir <= 32'h0000_0020 + i;
			fire(1'b1, 1'b0, 1'b0);
			rd(`REG_TOTAL_CAP, 32'h0000_0200 + i);
			rd(`REG_PER_DIR, 32'h0000_0020 + i);
		end
		bus(1'b1, `REG_CMD, {29'h0, `CMD_SHUTDOWN});
		fire(1'b1, 1'b0, 1'b0);
		// The drive flag drops one edge after the state does
		@(posedge clk);
		chk(active, 0);
		n = starts;
		bus(1'b1, `REG_CMD, {29'h0, `CMD_WRITE});
		rd(`REG_STATUS, 0);
		chk(starts, n);
		summarize();
	end
endmodule : fs_cmd_port_tb
